//--- src/srq_status_unit.sv
// status reporting unit: sixteen-bit register groups, status byte, event
// status register, error queue and the service request line.
// assumes commands, events and poll requests come from a parser on clk;
// the condition pins are asynchronous and are synchronised here.

// Notes on behaviour
// - overload of input n sets bit n-1
// - any channel temperature warning/error sets bit 0/1
// - clip upper even bit, lower odd bit
// - measurement k limit violation sets bit k-1
// - first mask test violation sets bit 0
// - enabled status byte bits raise service request
// - summaries gather enabled lower-level bits
// - queries return the plain binary register value
// - byte registers 8 bits, groups 16 bits
// - errors append; reads pop; empty answers zero
// - power-on-clear and clear-status wipe event parts
// - preset restores enables; byte enables only power-on
// - preset fills rising filters, clears falling filters
// - power-on and device clear flush buffers; power-on and clear-status flush queue
// - first command after terminator flushes output if reset, preset or clear-status armed it
// - only reset command alters instrument settings
// - serial poll returns the status byte
// - questionable summary bits 3,4,5,8,9,12; 15 zero
module srq_status_unit (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire srq_pkg::srq_pins_type pins,
	input  wire logic [15:0]           oper_cond,
	input  wire logic                  pon_event,
	input  wire logic                  dev_clear,
	input  wire logic                  mav,
	input  wire logic [7:0]            esr_events,
	input  wire logic                  err_push,
	input  wire logic [15:0]           err_code_in,
	input  wire logic                  cmd_valid,
	input  wire srq_pkg::srq_cmd_type  cmd,
	input  wire logic                  poll_req,
	output logic                       rsp_valid,
	output logic [15:0]                rsp_data,
	output logic                       poll_valid,
	output logic [7:0]                 poll_byte,
	output logic                       srq,
	output logic                       out_flush,
	output logic                       in_flush,
	output logic                       settings_reset
);

	// part selection shared by the read path
	function automatic logic [15:0] pick_part(
		input srq_pkg::srq_part_type part,
		input logic [15:0] c,
		input logic [15:0] e,
		input logic [15:0] en,
		input logic [15:0] r,
		input logic [15:0] f
	);
		case (part)
			srq_pkg::PART_COND:   pick_part = c;
			srq_pkg::PART_EVENT:  pick_part = e;
			srq_pkg::PART_ENABLE: pick_part = en;
			srq_pkg::PART_RISE:   pick_part = r;
			srq_pkg::PART_FALL:   pick_part = f;
			default:              pick_part = srq_pkg::REG_ZERO;
		endcase
	endfunction : pick_part

	srq_pkg::srq_pins_type pins_meta_reg;
	srq_pkg::srq_pins_type pins_reg;

	logic [7:0]  sre_reg;
	logic [7:0]  ese_reg;
	logic [7:0]  esr_reg;
	logic        psc_reg;
	logic        arm_reg;
	logic        rsp_valid_reg;
	logic [15:0] rsp_data_reg;
	logic        poll_valid_reg;
	logic [7:0]  poll_byte_reg;
	logic        srq_reg;
	logic        out_flush_reg;
	logic        in_flush_reg;
	logic        settings_reset_reg;

	logic [15:0] cond_vec   [srq_pkg::NUM_REGS];
	logic [15:0] cond_q     [srq_pkg::NUM_REGS];
	logic [15:0] event_q    [srq_pkg::NUM_REGS];
	logic [15:0] enable_q   [srq_pkg::NUM_REGS];
	logic [15:0] rise_q     [srq_pkg::NUM_REGS];
	logic [15:0] fall_q     [srq_pkg::NUM_REGS];
	logic [srq_pkg::NUM_REGS-1:0] summary;
	logic [15:0] clip_bits;
	logic [15:0] ques_cond;

	wire         is_rd_stb;
	wire         is_rd_esr;
	wire         is_rd_reg;
	wire         is_wr_reg;
	wire         is_rd_err;
	wire         is_cls;
	wire         is_preset;
	wire         is_rst;
	wire         pon_clear;
	wire         full_clear;
	wire         preset_all;
	wire         errq_flush;
	wire         errq_not_empty;
	wire [15:0]  errq_head;
	wire [7:0]   stb_base;
	wire         mss;
	wire [7:0]   stb_word;
	wire [7:0]   esr_next;
	wire [15:0]  reg_rd_data;
	wire         out_flush_next;

	// pins cross into the clock domain through two flip-flops
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pins_meta_reg <= '0;
			pins_reg      <= '0;
		end
		else
		begin
			pins_meta_reg <= pins;
			pins_reg      <= pins_meta_reg;
		end
	end

	// command decode
	assign is_rd_stb  = cmd_valid && (cmd.op == srq_pkg::OP_RD_STB);
	assign is_rd_esr  = cmd_valid && (cmd.op == srq_pkg::OP_RD_ESR);
	assign is_rd_reg  = cmd_valid && (cmd.op == srq_pkg::OP_RD_REG);
	assign is_wr_reg  = cmd_valid && (cmd.op == srq_pkg::OP_WR_REG);
	assign is_rd_err  = cmd_valid && (cmd.op == srq_pkg::OP_RD_ERR);
	assign is_cls     = cmd_valid && (cmd.op == srq_pkg::OP_CLS);
	assign is_preset  = cmd_valid && (cmd.op == srq_pkg::OP_PRESET);
	assign is_rst     = cmd_valid && (cmd.op == srq_pkg::OP_RST);
	assign pon_clear  = pon_event && psc_reg;
	assign full_clear = is_cls || pon_clear;
	assign preset_all = is_preset || pon_clear;
	assign errq_flush = pon_event || is_cls;

	// condition words of each group
	generate
		for (genvar n = 0; n < 4; n++)
		begin : g_clip
			assign clip_bits[2*n]   = pins_reg.clip_upper[n];
			assign clip_bits[2*n+1] = pins_reg.clip_lower[n];
		end
	endgenerate
	assign clip_bits[15:8] = 8'h00;

	assign cond_vec[srq_pkg::IDX_OPER]  = {1'b0, oper_cond[14:0]};
	assign cond_vec[srq_pkg::IDX_OVL]   = {12'h000, pins_reg.channel_overload};
	assign cond_vec[srq_pkg::IDX_TEMP]  = {14'h0000, |pins_reg.temp_error,
		|pins_reg.temp_warn};
	assign cond_vec[srq_pkg::IDX_CLIP]  = clip_bits;
	assign cond_vec[srq_pkg::IDX_LIMIT] = {8'h00, pins_reg.limit_violation};
	assign cond_vec[srq_pkg::IDX_MASK]  = {15'h0000, pins_reg.first_mask_test};

	// questionable summary gathers the lower groups; bit 15 stays zero
	// built in its own variable so the array element has a single driver
	always_comb
	begin
		ques_cond = srq_pkg::REG_ZERO;
		ques_cond[srq_pkg::QS_OVL]   = summary[srq_pkg::IDX_OVL];
		ques_cond[srq_pkg::QS_TEMP]  = summary[srq_pkg::IDX_TEMP];
		ques_cond[srq_pkg::QS_CLIP]  = summary[srq_pkg::IDX_CLIP];
		ques_cond[srq_pkg::QS_UNCAL] = pins_reg.uncalibrated_flag;
		ques_cond[srq_pkg::QS_LIMIT] = summary[srq_pkg::IDX_LIMIT];
		ques_cond[srq_pkg::QS_MASK]  = summary[srq_pkg::IDX_MASK];
	end
	assign cond_vec[srq_pkg::IDX_QUES] = ques_cond;

	// one register group per index; only operation and questionable preset
	// their enables to zero
	generate
		for (genvar i = 0; i < srq_pkg::NUM_REGS; i++)
		begin : g_grp
			srq_scpi_reg #(
				.ENABLE_ONES (i > srq_pkg::IDX_QUES)
			) u_grp (
				.clk      (clk),
				.rst      (rst),
				.cond     (cond_vec[i]),
				.wr_en    (is_wr_reg && (cmd.sel == 3'(i))),
				.wr_part  (cmd.part),
				.wr_data  (cmd.data),
				.ev_read  (is_rd_reg && (cmd.sel == 3'(i)) &&
					(cmd.part == srq_pkg::PART_EVENT)),
				.ev_clear (full_clear),
				.preset   (preset_all),
				.cond_q   (cond_q[i]),
				.event_q  (event_q[i]),
				.enable_q (enable_q[i]),
				.rise_q   (rise_q[i]),
				.fall_q   (fall_q[i]),
				.summary  (summary[i])
			);
		end
	endgenerate

	srq_err_queue #(
		.DEPTH (srq_pkg::ERRQ_DEPTH)
	) u_errq (
		.clk       (clk),
		.rst       (rst),
		.push      (err_push),
		.code_in   (err_code_in),
		.pop       (is_rd_err),
		.flush     (errq_flush),
		.head      (errq_head),
		.not_empty (errq_not_empty)
	);

	// status byte: each summary bit combines a lower level source
	assign stb_base = {summary[srq_pkg::IDX_OPER], 1'b0, |(esr_reg & ese_reg), mav,
		summary[srq_pkg::IDX_QUES], errq_not_empty, 2'b00};
	assign mss      = |(stb_base & sre_reg & srq_pkg::STB_SRQ_MASK);
	assign stb_word = stb_base | {1'b0, mss, 6'h00};

	// new events win over a clear or a destructive read in the same cycle
	assign esr_next = ((full_clear || is_rd_esr) ? srq_pkg::BYTE_ZERO : esr_reg) |
		esr_events | {pon_event, 7'h00};

	// register read path returns the plain binary value
	assign reg_rd_data = (cmd.sel < 3'(srq_pkg::NUM_REGS)) ?
		pick_part(cmd.part, cond_q[cmd.sel], event_q[cmd.sel], enable_q[cmd.sel],
			rise_q[cmd.sel], fall_q[cmd.sel]) : srq_pkg::REG_ZERO;

	// output buffer is flushed by clears, or by the first command of a line
	// once a reset, preset or clear status has armed the flush
	assign out_flush_next = pon_event || dev_clear ||
		(arm_reg && cmd_valid && cmd.line_start);

	// byte level registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sre_reg <= srq_pkg::BYTE_ZERO;
			ese_reg <= srq_pkg::BYTE_ZERO;
			esr_reg <= srq_pkg::ESR_RESET;
			psc_reg <= srq_pkg::PSC_RESET;
		end
		else
		begin
			esr_reg <= esr_next;
			if (pon_clear)
			begin
				sre_reg <= srq_pkg::BYTE_ZERO;
				ese_reg <= srq_pkg::BYTE_ZERO;
			end
			else if (cmd_valid && cmd.op == srq_pkg::OP_WR_SRE)
				sre_reg <= cmd.data[7:0];
			else if (cmd_valid && cmd.op == srq_pkg::OP_WR_ESE)
				ese_reg <= cmd.data[7:0];
			if (cmd_valid && cmd.op == srq_pkg::OP_WR_PSC)
				psc_reg <= cmd.data[0];
		end
	end

	// query answers; a query is always answered in the next cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rsp_valid_reg <= 1'b0;
			rsp_data_reg  <= srq_pkg::REG_ZERO;
		end
		else
		begin
			rsp_valid_reg <= is_rd_stb || is_rd_esr || is_rd_reg || is_rd_err ||
				(cmd_valid && (cmd.op == srq_pkg::OP_RD_SRE || cmd.op == srq_pkg::OP_RD_ESE));
			case (cmd_valid ? cmd.op : srq_pkg::OP_NONE)
				srq_pkg::OP_RD_STB: rsp_data_reg <= {8'h00, stb_word};
				srq_pkg::OP_RD_ESR: rsp_data_reg <= {8'h00, esr_reg};
				srq_pkg::OP_RD_SRE: rsp_data_reg <= {8'h00, sre_reg};
				srq_pkg::OP_RD_ESE: rsp_data_reg <= {8'h00, ese_reg};
				srq_pkg::OP_RD_REG: rsp_data_reg <= reg_rd_data;
				srq_pkg::OP_RD_ERR: rsp_data_reg <= errq_head;
				default:            rsp_data_reg <= rsp_data_reg;
			endcase
		end
	end

	// serial poll, service request and flush strobes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			poll_valid_reg     <= 1'b0;
			poll_byte_reg      <= srq_pkg::BYTE_ZERO;
			srq_reg            <= 1'b0;
			out_flush_reg      <= 1'b0;
			in_flush_reg       <= 1'b0;
			settings_reset_reg <= 1'b0;
			arm_reg            <= 1'b0;
		end
		else
		begin
			poll_valid_reg <= poll_req;
			if (poll_req)
				poll_byte_reg <= stb_word;
			srq_reg            <= mss;
			out_flush_reg      <= out_flush_next;
			in_flush_reg       <= pon_event || dev_clear;
			settings_reset_reg <= is_rst;
			if (is_rst || is_preset || is_cls)
				arm_reg <= 1'b1;
			else if (cmd_valid && cmd.line_start)
				arm_reg <= 1'b0;
		end
	end

	assign rsp_valid      = rsp_valid_reg;
	assign rsp_data       = rsp_data_reg;
	assign poll_valid     = poll_valid_reg;
	assign poll_byte      = poll_byte_reg;
	assign srq            = srq_reg;
	assign out_flush      = out_flush_reg;
	assign in_flush       = in_flush_reg;
	assign settings_reset = settings_reset_reg;

	srq_raise_a: assert property (@(posedge clk) disable iff (rst)
		(|(stb_base & sre_reg & 8'hbc)) |=> srq)
		else $error("service request not raised");

	srq_quiet_a: assert property (@(posedge clk) disable iff (rst)
		((stb_base & sre_reg & 8'hbc) == 8'h00) |=> !srq)
		else $error("service request without cause");

	esr_clear_a: assert property (@(posedge clk) disable iff (rst)
		(is_cls && esr_events == 8'h00 && !pon_event) |=> esr_reg == 8'h00)
		else $error("event status not cleared");

	byte_enable_a: assert property (@(posedge clk) disable iff (rst)
		(is_cls && !pon_event) |=> sre_reg == $past(sre_reg))
		else $error("clear status touched enable");

	flush_pair_a: assert property (@(posedge clk) disable iff (rst)
		dev_clear |=> out_flush && in_flush)
		else $error("device clear did not flush");

	poll_match_a: assert property (@(posedge clk) disable iff (rst)
		poll_req |=> poll_valid && poll_byte == $past(stb_word))
		else $error("serial poll value wrong");

	stb_query_a: assert property (@(posedge clk) disable iff (rst)
		is_rd_stb |=> rsp_valid && rsp_data == {8'h00, $past(stb_word)})
		else $error("status byte query wrong");

	settings_hold_a: assert property (@(posedge clk) disable iff (rst)
		(dev_clear || is_cls) && !is_rst |=> !settings_reset)
		else $error("clear changed settings");

	line_flush_a: assert property (@(posedge clk) disable iff (rst)
		is_cls ##1 (cmd_valid && cmd.line_start) |=> out_flush)
		else $error("armed flush missing");

endmodule : srq_status_unit

//--- src/srq_pkg.sv
// package for the status reporting unit: field positions, reset values,
// command codes and the carrier structs shared by all of its modules.
// assumes one clock domain; the asynchronous pins are synchronised in the top.
package srq_pkg;

	// register widths
	localparam int BYTE_W = 8;
	localparam int REG_W  = 16;

	// status byte bit positions
	localparam int STB_ERRQ = 2;
	localparam int STB_QUES = 3;
	localparam int STB_MAV  = 4;
	localparam int STB_ESB  = 5;
	localparam int STB_MSS  = 6;
	localparam int STB_OPER = 7;
	localparam logic [7:0] STB_SRQ_MASK = 8'hbc;

	// questionable summary bit positions
	localparam int QS_OVL   = 3;
	localparam int QS_TEMP  = 4;
	localparam int QS_CLIP  = 5;
	localparam int QS_UNCAL = 8;
	localparam int QS_LIMIT = 9;
	localparam int QS_MASK  = 12;

	// temperature register bit positions
	localparam int TEMP_WARN = 0;
	localparam int TEMP_ERR  = 1;

	// event status bit set at power on
	localparam int ESR_PON = 7;

	// reset values
	localparam logic [7:0]  ESR_RESET  = 8'h80;
	localparam logic [7:0]  BYTE_ZERO  = 8'h00;
	localparam logic [15:0] REG_ZERO   = 16'h0000;
	localparam logic [15:0] REG_ONES   = 16'hffff;
	localparam logic        PSC_RESET  = 1'b1;

	// error queue
	localparam int ERRQ_DEPTH = 8;
	localparam logic [15:0] NO_ERROR = 16'h0000;

	// index of each sixteen-bit register group
	localparam int IDX_OPER  = 0;
	localparam int IDX_QUES  = 1;
	localparam int IDX_OVL   = 2;
	localparam int IDX_TEMP  = 3;
	localparam int IDX_CLIP  = 4;
	localparam int IDX_LIMIT = 5;
	localparam int IDX_MASK  = 6;
	localparam int NUM_REGS  = 7;

	typedef enum logic [2:0]
	{
		PART_COND   = 3'h0,
		PART_EVENT  = 3'h1,
		PART_ENABLE = 3'h3,
		PART_RISE   = 3'h2,
		PART_FALL   = 3'h6
	} srq_part_type;

	typedef enum logic [3:0]
	{
		OP_NONE     = 4'h0,
		OP_RD_STB   = 4'h1,
		OP_RD_ESR   = 4'h3,
		OP_RD_SRE   = 4'h2,
		OP_RD_ESE   = 4'h6,
		OP_WR_SRE   = 4'h7,
		OP_WR_ESE   = 4'h5,
		OP_RD_REG   = 4'h4,
		OP_WR_REG   = 4'hc,
		OP_RD_ERR   = 4'hd,
		OP_CLS      = 4'hf,
		OP_PRESET   = 4'he,
		OP_RST      = 4'ha,
		OP_WR_PSC   = 4'hb
	} srq_op_type;

	// one command from the parser
	typedef struct packed
	{
		srq_op_type   op;
		logic [2:0]   sel;
		srq_part_type part;
		logic         line_start;
		logic [15:0]  data;
	} srq_cmd_type;

	// condition pins coming from the acquisition front end
	typedef struct packed
	{
		logic [3:0] channel_overload;
		logic [3:0] temp_warn;
		logic [3:0] temp_error;
		logic [3:0] clip_upper;
		logic [3:0] clip_lower;
		logic [7:0] limit_violation;
		logic       first_mask_test;
		logic       uncalibrated_flag;
	} srq_pins_type;

endpackage : srq_pkg

//--- src/srq_scpi_reg.sv
// one sixteen-bit status register group: condition, transition filters,
// sticky event part and enable part, with its summary bit.
// assumes cond comes from logic on the same clock.
module srq_scpi_reg #(
	parameter logic ENABLE_ONES = 1'b0
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic [15:0]         cond,
	input  wire logic                wr_en,
	input  wire srq_pkg::srq_part_type wr_part,
	input  wire logic [15:0]         wr_data,
	input  wire logic                ev_read,
	input  wire logic                ev_clear,
	input  wire logic                preset,
	output logic      [15:0]         cond_q,
	output logic      [15:0]         event_q,
	output logic      [15:0]         enable_q,
	output logic      [15:0]         rise_q,
	output logic      [15:0]         fall_q,
	output logic                     summary
);

	localparam logic [15:0] EN_PRESET = ENABLE_ONES ? srq_pkg::REG_ONES : srq_pkg::REG_ZERO;

	logic [15:0] cond_reg;
	logic [15:0] event_reg;
	logic [15:0] enable_reg;
	logic [15:0] rise_reg;
	logic [15:0] fall_reg;
	wire  [15:0] edge_hits;
	wire  [15:0] event_next;

	// new edges win over a clear or a destructive read in the same cycle
	assign edge_hits  = (cond & ~cond_reg & rise_reg) | (~cond & cond_reg & fall_reg);
	assign event_next = ((ev_read || ev_clear) ? srq_pkg::REG_ZERO : event_reg) | edge_hits;

	// condition tracking and the sticky event part
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cond_reg  <= srq_pkg::REG_ZERO;
			event_reg <= srq_pkg::REG_ZERO;
		end
		else
		begin
			cond_reg  <= cond;
			event_reg <= event_next;
		end
	end

	// enable and filters: preset beats a write issued in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst || preset)
		begin
			enable_reg <= EN_PRESET;
			rise_reg   <= srq_pkg::REG_ONES;
			fall_reg   <= srq_pkg::REG_ZERO;
		end
		else if (wr_en)
		begin
			if (wr_part == srq_pkg::PART_ENABLE)
				enable_reg <= wr_data;
			if (wr_part == srq_pkg::PART_RISE)
				rise_reg <= wr_data;
			if (wr_part == srq_pkg::PART_FALL)
				fall_reg <= wr_data;
		end
	end

	assign cond_q   = cond_reg;
	assign event_q  = event_reg;
	assign enable_q = enable_reg;
	assign rise_q   = rise_reg;
	assign fall_q   = fall_reg;
	assign summary  = |(event_reg & enable_reg);

	filter_preset_a: assert property (@(posedge clk) disable iff (rst)
		preset |=> rise_reg == 16'hffff && fall_reg == 16'h0000)
		else $error("filters not preset");

	rise_capture_a: assert property (@(posedge clk) disable iff (rst)
		(|(cond & ~cond_reg & rise_reg)) |=> (event_reg & $past(cond)) != 16'h0000)
		else $error("rising edge not captured");

endmodule : srq_scpi_reg

//--- src/srq_err_queue.sv
// error queue: first in, first out store of signed error codes.
// assumes push and pop come from logic on the same clock; a push into a full
// queue is dropped, keeping the oldest entries.
module srq_err_queue #(
	parameter int DEPTH = srq_pkg::ERRQ_DEPTH
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        push,
	input  wire logic [15:0] code_in,
	input  wire logic        pop,
	input  wire logic        flush,
	output logic      [15:0] head,
	output logic             not_empty
);

	localparam int AW = $clog2(DEPTH);

	logic [15:0] mem [DEPTH];
	logic [AW-1:0] rd_ptr_reg;
	logic [AW-1:0] wr_ptr_reg;
	logic [AW:0]   count_reg;
	wire           do_pop;
	wire           do_push;

	assign do_pop  = pop && (count_reg != '0);
	assign do_push = push && ((count_reg != DEPTH[AW:0]) || do_pop);

	// pointers and fill level
	always_ff @(posedge clk)
	begin
		if (rst || flush)
		begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (do_pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (do_push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			count_reg <= count_reg + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
		end
	end

	always_ff @(posedge clk)
	begin
		if (do_push)
			mem[wr_ptr_reg] <= code_in;
	end

	// an empty queue answers with the no-error code
	assign head      = (count_reg == '0) ? srq_pkg::NO_ERROR : mem[rd_ptr_reg];
	assign not_empty = (count_reg != '0);

	empty_answer_a: assert property (@(posedge clk) disable iff (rst)
		(count_reg == 1 && pop && !push && !flush) |=> head == 16'h0000)
		else $error("empty queue gave a code");

	push_count_a: assert property (@(posedge clk) disable iff (rst)
		(push && !pop && !flush && count_reg == '0) |=> count_reg == 1)
		else $error("entry not appended");

endmodule : srq_err_queue

//--- bench/srq_host_model.sv
// remote controller model: issues one command or one serial poll per call.
// assumes the unit answers a read or a poll exactly one cycle after taking it.
module srq_host_model (
	input  wire logic            clk,
	input  wire logic [15:0]     rsp_data,
	input  wire logic [7:0]      poll_byte,
	output srq_pkg::srq_cmd_type cmd,
	output logic                 cmd_valid,
	output logic                 poll_req
);
	timeunit 1ns;
	timeprecision 1ps;

	// line start flag carried by the next command
	logic ls = 1'b0;

	// idle until the bench asks for traffic
	initial
	begin
		cmd = '0;
		cmd_valid = 1'b0;
		poll_req = 1'b0;
	end

	// one command for one edge; the answer is settled just after the next edge
	task automatic send(input srq_pkg::srq_op_type op, input logic [2:0] sel,
		input srq_pkg::srq_part_type p, input logic [15:0] d, output logic [15:0] q);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= '{op, sel, p, ls, d};
		@(posedge clk);
		cmd_valid <= 1'b0;
		#1 q = rsp_data;
	endtask : send

	// serial poll through the interface path, not the command path
	task automatic poll(output logic [7:0] b);
		@(posedge clk);
		poll_req <= 1'b1;
		@(posedge clk);
		poll_req <= 1'b0;
		#1 b = poll_byte;
	endtask : poll
endmodule : srq_host_model

//--- bench/tb.sv
// self-checking bench for the status unit, expectations kept in logic vectors, error codes in an int queue.
// assumes fixed answer latencies; no wait depends on a design handshake.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	srq_pkg::srq_pins_type pins = '0;
	logic mav = 1'b0;
	logic err_push = 1'b0;
	logic [15:0] err_code_in = 16'h0000;
	srq_pkg::srq_cmd_type cmd;
	logic cmd_valid, poll_req, rsp_valid, poll_valid, srq;
	logic [15:0] rsp_data;
	logic out_flush, in_flush, settings_reset;
	logic dev_clear = 1'b0;
	logic pon_event = 1'b0;
	logic [7:0] poll_byte;
	integer seed = 99415;
	int bad_count = 0;
	int tests_run = 0;
	int errq[$];
	logic [31:0] v;
	logic [15:0] r, e;
	logic [7:0] b, s;

	always #2 clk = ~clk;

	srq_status_unit DUT (.clk(clk), .rst(rst), .pins(pins), .oper_cond(16'h0000),
		.pon_event(pon_event), .dev_clear(dev_clear), .mav(mav), .esr_events(8'h00),
		.err_push(err_push), .err_code_in(err_code_in), .cmd_valid(cmd_valid),
		.cmd(cmd), .poll_req(poll_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.poll_valid(poll_valid), .poll_byte(poll_byte), .srq(srq), .out_flush(out_flush),
		.in_flush(in_flush), .settings_reset(settings_reset));
	srq_host_model host (.clk(clk), .rsp_data(rsp_data), .poll_byte(poll_byte),
		.cmd(cmd), .cmd_valid(cmd_valid), .poll_req(poll_req));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// read one part of one register group and compare
	task automatic rg(input srq_pkg::srq_part_type p, input int sl, input logic [15:0] x);
		logic [15:0] q;
		host.send(srq_pkg::OP_RD_REG, 3'(sl), p, 16'h0000, q);
		check("reg", q, x);
		check("rsp_valid", {15'h0, rsp_valid}, 16'h0001);
	endtask : rg

	task automatic give_verdict;
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// reset defaults of every group; reading the event status clears it
		host.send(srq_pkg::OP_RD_ESR, 3'h0, srq_pkg::PART_COND, 16'h0000, r);
		check("esr", r, 16'h0080);
		for (int i = 0; i < 7; i++)
		begin
			rg(srq_pkg::PART_ENABLE, i, (i < 2) ? 16'h0000 : 16'hffff);
			rg(srq_pkg::PART_RISE, i, 16'hffff);
			rg(srq_pkg::PART_FALL, i, 16'h0000);
		end
		// random condition pins; the model works out each group's pattern
		@(posedge clk);
		v = $random(seed);
		pins <= srq_pkg::srq_pins_type'(v[29:0]);
		mav <= v[30];
		repeat (4) @(posedge clk);
		rg(srq_pkg::PART_COND, 2, {12'h000, pins.channel_overload});
		rg(srq_pkg::PART_COND, 3, {14'h0, |pins.temp_error, |pins.temp_warn});
		for (int n = 0; n < 4; n++)
			{e[2 * n + 1], e[2 * n]} = {pins.clip_lower[n], pins.clip_upper[n]};
		e[15:8] = 8'h00;
		rg(srq_pkg::PART_COND, 4, e);
		rg(srq_pkg::PART_COND, 5, {8'h00, pins.limit_violation});
		rg(srq_pkg::PART_COND, 6, {15'h0, pins.first_mask_test});
		e = 16'h0000;
		e[3] = |pins.channel_overload;
		e[4] = |{pins.temp_error, pins.temp_warn};
		e[5] = |{pins.clip_lower, pins.clip_upper};
		e[8] = pins.uncalibrated_flag;
		e[9] = |pins.limit_violation;
		e[12] = pins.first_mask_test;
		rg(srq_pkg::PART_COND, 1, e);
		// host opens the questionable, request and event enables so any pin condition can reach the service line
		host.send(srq_pkg::OP_WR_REG, 3'h1, srq_pkg::PART_ENABLE, 16'hffff, r);
		host.send(srq_pkg::OP_WR_SRE, 3'h0, srq_pkg::PART_COND, 16'h00ff, r);
		host.send(srq_pkg::OP_WR_ESE, 3'h0, srq_pkg::PART_COND, 16'h00ff, r);
		for (int k = 0; k < 2; k++)
		begin
			v = $random(seed);
			@(posedge clk);
			err_push <= 1'b1;
			err_code_in <= v[15:0];
			errq.push_back(int'(v[15:0]));
		end
		@(posedge clk);
		err_push <= 1'b0;
		s = {1'b0, 1'b0, 1'b0, mav, |e[14:0], 1'b1, 2'b00};
		s[6] = |(s & 8'hbc);
		host.poll(b);
		check("poll", {8'h00, b}, {8'h00, s});
		check("poll_valid", {15'h0, poll_valid}, 16'h0001);
		host.send(srq_pkg::OP_RD_STB, 3'h0, srq_pkg::PART_COND, 16'h0000, r);
		check("stb", r, {8'h00, s});
		check("srq", {15'h0, srq}, {15'h0, s[6]});
		for (int k = 0; k < 3; k++)
		begin
			host.send(srq_pkg::OP_RD_ERR, 3'h0, srq_pkg::PART_COND, 16'h0000, r);
			check("err", r, (errq.size() > 0) ? 16'(errq.pop_front()) : 16'h0000);
		end
		// clear status drops the queue and the event parts, not the conditions
		@(posedge clk);
		err_push <= 1'b1;
		@(posedge clk);
		err_push <= 1'b0;
		host.send(srq_pkg::OP_CLS, 3'h0, srq_pkg::PART_COND, 16'h0000, r);
		host.send(srq_pkg::OP_RD_ERR, 3'h0, srq_pkg::PART_COND, 16'h0000, r);
		check("err", r, 16'h0000);
		rg(srq_pkg::PART_EVENT, 2, 16'h0000);
		s = {1'b0, mav, 1'b0, mav, 4'h0};
		host.send(srq_pkg::OP_RD_STB, 3'h0, srq_pkg::PART_COND, 16'h0000, r);
		check("stb", r, {8'h00, s});
		// preset refills filters and group enables but leaves the byte enables
		host.send(srq_pkg::OP_WR_REG, 3'h3, srq_pkg::PART_RISE, 16'h0000, r);
		host.send(srq_pkg::OP_PRESET, 3'h0, srq_pkg::PART_COND, 16'h0000, r);
		rg(srq_pkg::PART_RISE, 3, 16'hffff);
		rg(srq_pkg::PART_ENABLE, 1, 16'h0000);
		host.send(srq_pkg::OP_RD_SRE, 3'h0, srq_pkg::PART_COND, 16'h0000, r);
		check("sre", r, 16'h00ff);
		host.send(srq_pkg::OP_RST, 3'h0, srq_pkg::PART_COND, 16'h0000, r);
		check("settings", {15'h0, settings_reset}, 16'h0001);
		// first command of a new line after the reset command flushes output
		host.ls = 1'b1;
		host.send(srq_pkg::OP_RD_ESE, 3'h0, srq_pkg::PART_COND, 16'h0000, r);
		host.ls = 1'b0;
		check("ese", r, 16'h00ff);
		check("out_flush", {15'h0, out_flush}, 16'h0001);
		// device clear and power-on each flush the buffers for one cycle
		@(posedge clk);
		dev_clear <= 1'b1;
		@(posedge clk);
		dev_clear <= 1'b0;
		#1 check("in_flush", {15'h0, in_flush}, 16'h0001);
		check("out_flush", {15'h0, out_flush}, 16'h0001);
		check("settings", {15'h0, settings_reset}, 16'h0000);
		@(posedge clk);
		pon_event <= 1'b1;
		@(posedge clk);
		pon_event <= 1'b0;
		#1 check("in_flush", {15'h0, in_flush}, 16'h0001);
		host.send(srq_pkg::OP_RD_SRE, 3'h0, srq_pkg::PART_COND, 16'h0000, r);
		check("sre", r, 16'h0000);
		give_verdict();
	end
endmodule : tb
